// File: core/scs_clkgen.sv
// Card clock divider with even halves for a 50 percent duty cycle
`timescale 1ns/1ns
`default_nettype none
module scs_clkgen
  import scs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [5:0] half_per,
  output logic            card_clk,
  output logic            clk_rise
);

  logic [5:0] half;
  logic [5:0] cnt_q;

  // ==========================================================================
  // Clamp keeps the card clock in its legal band whatever software writes
  always_comb
  begin
    if (half_per < HALF_MIN)
      half = HALF_MIN;
    else if (half_per > HALF_MAX)
      half = HALF_MAX;
    else
      half = half_per;
  end

  // ==========================================================================
  // Equal high and low halves; stopped clock parks low
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_q    <= 6'h00;
      card_clk <= 1'b0;
      clk_rise <= 1'b0;
    end
    else if (cnt_q >= half - 6'h01)
    begin
      cnt_q    <= 6'h00;
      card_clk <= ~card_clk;
      clk_rise <= ~card_clk;
    end
    else
    begin
      cnt_q    <= cnt_q + 6'h01;
      clk_rise <= 1'b0;
    end
  end

endmodule // scs_clkgen
`default_nettype wire

// File: core/scs_ctrl.sv
// Terminal-side supply class sequencer with AXI4-Lite control registers
`timescale 1ns/1ns
`default_nettype none
module scs_ctrl
  import scs_pkg::*;
#(
  parameter int unsigned ATR_WAIT_CLKS = ATR_WAIT_CLKS_DEF
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire scs_atr_t    answer_to_reset,
  output scs_card_t        card,
  output logic             atr_rx_en,
  output logic             reset_warm,
  output logic             irq
);

  // ==========================================================================
  // Helpers
  // Lowest voltage class present in a mask (highest index set)
  function automatic logic [1:0] lowest_cls(input logic [2:0] m);
    if (m[2])
      return 2'd2;
    else if (m[1])
      return 2'd1;
    else
      return 2'd0;
  endfunction

  // Byte-lane merge of a register write
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // ==========================================================================
  // Declarations
  logic             aw_have_q;
  logic [7:0]       awaddr_q;
  logic             w_have_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;
  logic             wr_fire;
  logic [31:0]      ctrl_wr;
  logic             cmd_start;
  logic             cmd_stop;
  logic             cmd_warm;
  logic             esc_en_q;
  logic [2:0]       term_m_q;
  logic [5:0]       half_q;
  logic [EV_W-1:0]  irq_stat_q;
  logic [EV_W-1:0]  irq_en_q;
  logic [EV_W-1:0]  ev_q;
  scs_state_t       state_q;
  logic [1:0]       cls_q;
  logic [1:0]       crpt_q;
  logic             first_q;
  logic             esc_q;
  logic             warm_q;
  logic             relaunch_q;
  logic             reject_q;
  logic [15:0]      tmr_q;
  logic [7:0]       ind_q;
  logic             up_ok;
  logic [2:0]       adv_m;
  logic             clk_run;
  logic             vcc_en_q;
  logic [2:0]       vcc_sel_q;
  logic             rst_n_q;
  logic             clk_out;
  logic             clk_rise;

  // ==========================================================================
  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        case (awaddr_q)
          REG_CTRL, REG_CFG, REG_IRQ_CLR, REG_IRQ_EN: bresp_q <= 2'h0;
          default:                                   bresp_q <= 2'h2;
        endcase
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Command pulses: only on the write that reaches CTRL
  assign ctrl_wr   = wmerge(32'h0000_0000, wdata_q, wstrb_q);
  assign cmd_start = wr_fire && (awaddr_q == REG_CTRL) && ctrl_wr[CTRL_START];
  assign cmd_stop  = wr_fire && (awaddr_q == REG_CTRL) && ctrl_wr[CTRL_STOP];
  assign cmd_warm  = wr_fire && (awaddr_q == REG_CTRL) && ctrl_wr[CTRL_WARM];

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      esc_en_q <= ESC_EN_RST;
      term_m_q <= CFG_CLASSES_RST;
      half_q   <= CFG_HALF_RST;
      irq_en_q <= '0;
    end
    else if (wr_fire)
    begin
      case (awaddr_q)
        REG_CTRL:
          if (wstrb_q[0])
            esc_en_q <= wdata_q[CTRL_ESC_EN];
        REG_CFG:
        begin
          if (wstrb_q[0])
            term_m_q <= wdata_q[2:0];
          if (wstrb_q[1])
            half_q <= wdata_q[CFG_HALF_LSB +: 6];
        end
        REG_IRQ_EN:
          if (wstrb_q[0])
            irq_en_q <= wdata_q[EV_W-1:0];
        default:
          irq_en_q <= irq_en_q;
      endcase
    end
  end

  // ==========================================================================
  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= '0;
    else if (wr_fire && awaddr_q == REG_IRQ_CLR && wstrb_q[0])
      irq_stat_q <= (irq_stat_q & ~wdata_q[EV_W-1:0]) | ev_q;
    else
      irq_stat_q <= irq_stat_q | ev_q;
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ==========================================================================
  // AXI4-Lite read: one answer per address, held until rready
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'h0;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= 2'h0;
      rdata_q  <= 32'h0000_0000;
      case (s_axi_araddr)
        REG_CTRL:     rdata_q[CTRL_ESC_EN] <= esc_en_q;
        REG_CFG:      rdata_q <= {18'h0, half_q, 5'h0, term_m_q};
        REG_STATUS:   rdata_q <= {16'h0, 3'h0, warm_q, 2'h0, crpt_q,
                                  2'h0, cls_q, 1'b0, state_q};
        REG_IRQ_STAT: rdata_q[EV_W-1:0] <= irq_stat_q;
        REG_IRQ_CLR:  rdata_q <= 32'h0000_0000;
        REG_IRQ_EN:   rdata_q[EV_W-1:0] <= irq_en_q;
        REG_IND:      rdata_q[7:0] <= ind_q;
        default:      rresp_q <= 2'h2;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ==========================================================================
  // Class decisions
  // Next higher voltage is the next lower index, if the terminal offers it
  assign up_ok = (cls_q != 2'd0) && term_m_q[cls_q - 2'd1];
  // Advertised classes the terminal can also drive; reserved D/E ignored
  assign adv_m = answer_to_reset.ind[2:0] & term_m_q;

  // ==========================================================================
  // Activation sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q    <= ST_IDLE;
      cls_q      <= 2'd0;
      crpt_q     <= 2'd0;
      first_q    <= 1'b0;
      esc_q      <= 1'b0;
      warm_q     <= 1'b0;
      relaunch_q <= 1'b0;
      reject_q   <= 1'b0;
      tmr_q      <= 16'h0000;
      ind_q      <= 8'h00;
      ev_q       <= '0;
    end
    else
    begin
      ev_q <= '0;
      case (state_q)
        ST_IDLE, ST_REJECT:
          if (cmd_start)
          begin
            tmr_q   <= 16'h0000;
            crpt_q  <= 2'd0;
            esc_q   <= 1'b0;
            warm_q  <= 1'b0;
            first_q <= 1'b1;
            if (|term_m_q)
            begin
              cls_q   <= lowest_cls(term_m_q);
              state_q <= ST_POWER;
            end
            else
            begin
              ev_q[EV_REJECT] <= 1'b1;
              state_q         <= ST_REJECT;
            end
          end
        ST_POWER:
          if (tmr_q == 16'(VCC_SETTLE_CYC - 1))
          begin
            tmr_q   <= 16'h0000;
            state_q <= ST_RST_LOW;
          end
          else
            tmr_q <= tmr_q + 16'h0001;
        ST_RST_LOW:
          if (tmr_q == 16'(RST_LOW_CLKS))
          begin
            tmr_q   <= 16'h0000;
            state_q <= ST_WAIT_ATR;
          end
          else if (clk_rise)
            tmr_q <= tmr_q + 16'h0001;
        ST_WAIT_ATR:
          if (answer_to_reset.done && !answer_to_reset.bad)
          begin
            crpt_q <= 2'd0;
            tmr_q  <= 16'h0000;
            if (answer_to_reset.ind_valid)
            begin
              ind_q <= answer_to_reset.ind;
              if (answer_to_reset.ind[0] && answer_to_reset.ind[2])
                ev_q[EV_NONADJ] <= 1'b1;
            end
            if (first_q && answer_to_reset.ind_valid && !answer_to_reset.ind[cls_q])
            begin
              // Re-power at the lowest advertised class the terminal offers; reject if it offers none
              relaunch_q <= |adv_m;
              reject_q   <= ~|adv_m;
              cls_q      <= lowest_cls(adv_m);
              first_q    <= 1'b0;
              ev_q[EV_SWITCH] <= |adv_m;
              state_q    <= ST_DEACT;
            end
            else
            begin
              first_q <= 1'b0;
              ev_q[EV_ACTIVE] <= 1'b1;
              state_q <= ST_ACTIVE;
            end
          end
          else if (answer_to_reset.done)
          begin
            ev_q[EV_CORRUPT] <= 1'b1;
            tmr_q   <= 16'h0000;
            state_q <= ST_DEACT;
            warm_q  <= 1'b0;
            if (!esc_q && crpt_q < 2'(RETRY_MAX - 1))
            begin
              crpt_q     <= crpt_q + 2'd1;
              relaunch_q <= 1'b1;
              reject_q   <= 1'b0;
            end
            else if (!esc_q && esc_en_q && up_ok)
            begin
              // Single retry, one class up and no further
              cls_q      <= cls_q - 2'd1;
              esc_q      <= 1'b1;
              crpt_q     <= 2'd0;
              relaunch_q <= 1'b1;
              reject_q   <= 1'b0;
              ev_q[EV_SWITCH] <= 1'b1;
            end
            else
            begin
              relaunch_q <= 1'b0;
              reject_q   <= 1'b1;
            end
          end
          else if (clk_rise && tmr_q == 16'(ATR_WAIT_CLKS - 1))
          begin
            // Silence: power down and climb one class if possible
            tmr_q      <= 16'h0000;
            state_q    <= ST_DEACT;
            warm_q     <= 1'b0;
            relaunch_q <= up_ok;
            reject_q   <= ~up_ok;
            crpt_q     <= 2'd0;
            if (up_ok)
            begin
              cls_q <= cls_q - 2'd1;
              ev_q[EV_SWITCH] <= 1'b1;
            end
          end
          else if (clk_rise)
            tmr_q <= tmr_q + 16'h0001;
        ST_DEACT:
          if (tmr_q == 16'(DEACT_CYC - 1))
          begin
            tmr_q <= 16'h0000;
            if (relaunch_q)
              state_q <= ST_POWER;
            else if (reject_q)
            begin
              ev_q[EV_REJECT] <= 1'b1;
              state_q <= ST_REJECT;
            end
            else
              state_q <= ST_IDLE;
          end
          else
            tmr_q <= tmr_q + 16'h0001;
        ST_ACTIVE:
          if (cmd_warm)
          begin
            // Keep power and clock; only reset is pulsed
            warm_q  <= 1'b1;
            tmr_q   <= 16'h0000;
            state_q <= ST_RST_LOW;
          end
        default:
          state_q <= ST_IDLE;
      endcase
      // Host stop overrides any sequence in progress
      if (cmd_stop && state_q != ST_IDLE && state_q != ST_REJECT)
      begin
        relaunch_q <= 1'b0;
        reject_q   <= 1'b0;
        tmr_q      <= 16'h0000;
        state_q    <= ST_DEACT;
      end
    end
  end

  // ==========================================================================
  // Contact drive, registered from the sequencer state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vcc_en_q     <= 1'b0;
      vcc_sel_q    <= 3'h0;
      rst_n_q      <= 1'b0;
      atr_rx_en    <= 1'b0;
      reset_warm   <= 1'b0;
    end
    else
    begin
      vcc_en_q     <= state_q inside {ST_POWER, ST_RST_LOW, ST_WAIT_ATR, ST_ACTIVE};
      vcc_sel_q    <= (state_q inside {ST_IDLE, ST_DEACT, ST_REJECT})
                      ? 3'h0 : 3'(3'h1 << cls_q);
      rst_n_q      <= state_q inside {ST_WAIT_ATR, ST_ACTIVE};
      // Receiver enabled only once a class is powered and reset released
      atr_rx_en    <= state_q inside {ST_WAIT_ATR, ST_ACTIVE};
      reset_warm   <= warm_q;
    end
  end

  // Unregistered run: card clock stops on the same edge as the supply
  assign clk_run = state_q inside {ST_RST_LOW, ST_WAIT_ATR, ST_ACTIVE};
  assign card    = '{vcc_en: vcc_en_q, vcc_sel: vcc_sel_q, rst_n: rst_n_q, clk: clk_out};

  // ==========================================================================
  // Card clock source
  scs_clkgen u_clkgen (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (clk_run),
    .half_per (half_q),
    .card_clk (clk_out),
    .clk_rise (clk_rise)
  );

endmodule // scs_ctrl
`default_nettype wire

// File: core/scs_pkg.sv
// Shared constants, types and register map of the supply class sequencer
package scs_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned T_VCC_SETTLE_NS  = 10000;
  localparam int unsigned T_DEACT_NS       = 10000;
  localparam int unsigned VCC_SETTLE_CYC   =
    (T_VCC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEACT_CYC        =
    (T_DEACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_LOW_CLKS     = 400;
  localparam int unsigned ATR_WAIT_CLKS_DEF = 40000;
  localparam int unsigned RETRY_MAX        = 3;
  // Card clock half period in system cycles: 5 MHz .. 1 MHz
  localparam logic [5:0]  HALF_MIN         = 6'h0A;
  localparam logic [5:0]  HALF_MAX         = 6'h32;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_CFG      = 8'h04;
  localparam logic [7:0]  REG_STATUS   = 8'h08;
  localparam logic [7:0]  REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0]  REG_IRQ_CLR  = 8'h10;
  localparam logic [7:0]  REG_IRQ_EN   = 8'h14;
  localparam logic [7:0]  REG_IND      = 8'h18;
  // Field positions
  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_STOP    = 1;
  localparam int unsigned CTRL_WARM    = 2;
  localparam int unsigned CTRL_ESC_EN  = 3;
  localparam int unsigned CFG_HALF_LSB = 8;
  // Reset values
  localparam logic [2:0]  CFG_CLASSES_RST = 3'h7;
  localparam logic [5:0]  CFG_HALF_RST    = 6'h32;
  localparam logic        ESC_EN_RST      = 1'b1;
  // Event bits
  localparam int unsigned EV_ACTIVE  = 0;
  localparam int unsigned EV_REJECT  = 1;
  localparam int unsigned EV_SWITCH  = 2;
  localparam int unsigned EV_CORRUPT = 3;
  localparam int unsigned EV_NONADJ  = 4;
  localparam int unsigned EV_W       = 5;
  // Class indices: 0 = A (highest voltage) .. 2 = C (lowest)
  localparam int unsigned CLS_N = 3;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE, ST_POWER, ST_RST_LOW, ST_WAIT_ATR, ST_DEACT, ST_ACTIVE, ST_REJECT
  } scs_state_t;

  // Report from the answer_to_reset receiver
  typedef struct packed {
    logic       done;       // one-cycle pulse: answer complete
    logic       bad;        // with done: answer corrupted
    logic       ind_valid;  // class_indication_byte present
    logic [7:0] ind;        // class_indication_byte
  } scs_atr_t;

  // Card contact drive
  typedef struct packed {
    logic       vcc_en;
    logic [2:0] vcc_sel;    // one-hot, bit i = class index i
    logic       rst_n;
    logic       clk;
  } scs_card_t;

endpackage : scs_pkg

// File: test/scs_card_model.sv
// Card model answering each activation attempt as its script says
`timescale 1ns/1ns
`default_nettype none
module scs_card_model
  import scs_pkg::*;
(
  input  wire logic       aclk,
  input  wire scs_card_t  card,
  input  wire logic [9:0] script [8],
  output scs_atr_t        answer_to_reset
);
  // ==========================================================================
  // Answer engine
  // Script entry: [9:8] 0 silent, 1 good, 2 corrupted; [7:0] indication
  int unsigned idx   = 0;
  int unsigned rises = 0;
  logic        clk_l = 1'b0;
  logic        rst_l = 1'b0;
  initial answer_to_reset = '0;
  // Attempt index moves on whenever rst_n falls: at a warm reset or at deactivation, not at first power up
  always @(posedge aclk)
  begin
    clk_l <= card.clk;
    rst_l <= card.rst_n;
    if (rst_l && !card.rst_n) idx <= idx + 1;
    if (!card.rst_n) rises <= 0;
    else if (card.clk && !clk_l) rises <= rises + 1;
    // Answer after 10 card clocks; idle lines show the inverse
    if (card.rst_n && card.clk && !clk_l && rises == 9 && script[idx][9:8] != 2'h0)
      answer_to_reset <= {1'b1, script[idx][9], 1'b1, script[idx][7:0]};
    else
      answer_to_reset <= {1'b0, ~answer_to_reset.bad, ~answer_to_reset.ind_valid, ~answer_to_reset.ind};
  end
endmodule // scs_card_model
`default_nettype wire

// File: test/scs_ctrl_props.sv
// Concurrent checks on the supply class sequencer's ports
`timescale 1ns/1ns
`default_nettype none
module scs_ctrl_props
  import scs_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire scs_card_t  card,
  input wire logic       atr_rx_en,
  input wire logic       reset_warm
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Helpers
  // High time of the card clock in system cycles
  logic [7:0] hi_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !card.clk) hi_q <= 8'h00;
    else hi_q <= hi_q + 8'h01;
  end
  // Reset and clock held off right after supply comes up
  sequence s_held_off;
    (!card.rst_n && !card.clk) [*8];
  endsequence
  // Supply fully removed, no class left selected
  sequence s_powered_off;
    (!card.vcc_en && card.vcc_sel == 3'h0) [*8];
  endsequence
  // ==========================================================================
  // Properties
  property p_one_class;
    card.vcc_en |-> $onehot(card.vcc_sel);
  endproperty
  a_one_class: assert property (p_one_class)
    else $error("supply class not one-hot");
  property p_class_hold;
    card.vcc_en && $past(card.vcc_en) |-> $stable(card.vcc_sel);
  endproperty
  a_class_hold: assert property (p_class_hold)
    else $error("class changed while powered");
  property p_power_up;
    $rose(card.vcc_en) |-> s_held_off;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("reset or clock active at power up");
  property p_deact;
    $fell(card.vcc_en) |-> s_powered_off;
  endproperty
  a_deact: assert property (p_deact)
    else $error("deactivation too short");
  property p_clk_off;
    !card.vcc_en |-> !card.clk;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("card clock runs unpowered");
  property p_half;
    $fell(card.clk) && card.vcc_en |-> hi_q >= 8'h0A && hi_q <= 8'h32;
  endproperty
  a_half: assert property (p_half)
    else $error("card clock high time out of range");
  property p_rst_release;
    $rose(card.rst_n) |-> card.vcc_en ##[0:1] atr_rx_en;
  endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("receiver not listening after reset");
  property p_cold;
    $rose(card.vcc_en) |=> !reset_warm;
  endproperty
  a_cold: assert property (p_cold)
    else $error("power up reset marked warm");
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("read answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
endmodule // scs_ctrl_props
`default_nettype wire

// File: test/scs_ctrl_tb.sv
// Register-level testbench of the supply class sequencer
`timescale 1ns/1ns
`default_nettype none
module scs_ctrl_tb
  import scs_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rv, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, atr_rx_en, reset_warm, irq;
  logic [1:0]  bresp, rresp, rr;
  scs_card_t   card;
  scs_atr_t    answer_to_reset;
  logic [9:0]  script [8];
  int          num_errors = 0, n_tests = 0;
  always #5 aclk = ~aclk;
  // ==========================================================================
  // Instances
  scs_ctrl #(.ATR_WAIT_CLKS(50)) u_scs_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .answer_to_reset(answer_to_reset), .card(card),
    .atr_rx_en(atr_rx_en), .reset_warm(reset_warm), .irq(irq));
  scs_card_model u_scs_card_model (.aclk(aclk), .card(card), .script(script), .answer_to_reset(answer_to_reset));
  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Write holds each channel until its own ready, response after both
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, rv);
  endtask
  task automatic ws(input logic [2:0] s);
    do rd(REG_STATUS);
    while (rv[2:0] !== s);
  endtask
  // Class applied at the next power up
  task automatic pw(input logic [2:0] e);
    @(posedge card.vcc_en);
    @(posedge aclk);
    chk("vcc_sel", {29'h0, e}, {29'h0, card.vcc_sel});
  endtask
  // ==========================================================================
  // Tests
  initial
  begin
    script = '{10'h000, 10'h101, 10'h101, 10'h101, 10'h200, 10'h200, 10'h200, 10'h200};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(REG_CFG, 32'h0000_3207, "cfg reset");
    rc(REG_STATUS, 32'h0, "status reset");
    rc(REG_IRQ_EN, 32'h0, "irq_en reset");
    wr(REG_STATUS, 32'h1, 2'h2);
    rd(8'h1C);
    chk("rresp unmapped", 32'h2, {30'h0, rr});
    $display("test registers done");
    wr(REG_CFG, 32'h0A07, 2'h0);
    wr(REG_IRQ_EN, 32'h1F, 2'h0);
    wr(REG_CTRL, 32'h9, 2'h0);
    pw(3'h4);
    pw(3'h2);
    pw(3'h1);
    ws(3'h5);
    rc(REG_STATUS, 32'h5, "status active");
    rc(REG_IND, 32'h1, "indication");
    chk("irq raised", 32'h1, {31'h0, irq});
    chk("cold flag", 32'h0, {31'h0, reset_warm});
    wr(REG_CTRL, 32'hC, 2'h0);
    ws(3'h5);
    chk("warm flag", 32'h1, {31'h0, reset_warm});
    rc(REG_STATUS, 32'h1005, "status warm");
    wr(REG_IRQ_CLR, 32'h1F, 2'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test step up done");
    wr(REG_CTRL, 32'hA, 2'h0);
    ws(3'h0);
    wr(REG_CFG, 32'h0A06, 2'h0);
    wr(REG_IRQ_EN, 32'h1, 2'h0);
    wr(REG_CTRL, 32'h9, 2'h0);
    pw(3'h4);
    pw(3'h4);
    rc(REG_STATUS, 32'h121, "one corrupt");
    pw(3'h4);
    pw(3'h2);
    rc(REG_STATUS, 32'h11, "count cleared");
    ws(3'h6);
    chk("vcc off", 32'h0, {31'h0, card.vcc_en});
    rd(REG_IRQ_STAT);
    chk("reject event", 32'h1, {31'h0, rv[EV_REJECT]});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(REG_IRQ_EN, 32'h2, 2'h0);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(REG_IRQ_CLR, 32'h2, 2'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test corrupt done");
    close_out();
  end
  // Watchdog at 1 ms, only about 200 us beyond the eight attempts of the run
  initial
  begin
    #1000000;
    num_errors++;
    close_out();
  end
endmodule // scs_ctrl_tb
bind scs_ctrl scs_ctrl_props u_scs_ctrl_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .card(card), .atr_rx_en(atr_rx_en),
  .reset_warm(reset_warm));
`default_nettype wire
